// *** rtl/kec_keypad_events.sv ***
// keypad event qualification: store enables, auto-repeat, touch limit, flags, irq
`timescale 1ns/1ps
module kec_keypad_events (
    input  wire logic                       ref_clk_i,
    input  wire logic                       arst_n_i,
    input  wire logic [kec_pkg::NUM_KEYS-1:0] touch_i,
    input  wire logic                       meas_done_i,
    input  wire logic [7:0]                 addr_i,
    input  wire logic [7:0]                 wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic [7:0]                      rdata_o,
    output logic [kec_pkg::NUM_KEYS-1:0]    reported_o,
    output logic                            cap_event_o,
    output logic                            irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers and measurement strobe edge
    logic [kec_pkg::NUM_KEYS-1:0]   touch_s1_reg;
    logic [kec_pkg::NUM_KEYS-1:0]   touch_s2_reg;
    logic [2:0]                     meas_sync_reg;
    logic                           meas_tick;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            touch_s1_reg  <= '0;
            touch_s2_reg  <= '0;
            meas_sync_reg <= 3'h0;
        end else begin
            touch_s1_reg  <= touch_i;
            touch_s2_reg  <= touch_s1_reg;
            meas_sync_reg <= {meas_sync_reg[1:0], meas_done_i};
        end
    end

    // one tick per completed measurement, taken from synchronised stages only
    assign meas_tick = meas_sync_reg[1] && !meas_sync_reg[2];

    ////////////////////////////////////////////////////////////////////////////
    // register file
    kec_pkg::kec_bus_req_t          req;
    logic [7:0]                     ctrl_reg;
    logic [7:0]                     rate_reg;
    logic [7:0]                     start_reg;
    logic [1:0]                     limit_reg;
    logic [kec_pkg::IRQ_W-1:0]      irq_stat_reg;
    logic [kec_pkg::IRQ_W-1:0]      irq_mask_reg;
    logic                           qfull_flag_reg;
    logic                           too_many_reg;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    function automatic logic hit(input kec_pkg::kec_bus_req_t r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction : hit

    logic [kec_pkg::NUM_KEYS-1:0]   key_now;
    logic [kec_pkg::NUM_KEYS-1:0]   key_prev_reg;
    logic [kec_pkg::NUM_KEYS-1:0]   rise;
    logic [kec_pkg::NUM_KEYS-1:0]   fall;
    logic                           rep_fire;
    logic [1:0]                     rep_key_reg;
    kec_pkg::kec_rep_state_t        rep_state_reg;
    logic [7:0]                     rep_cnt_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg  <= kec_pkg::RST_CTRL;
            rate_reg  <= kec_pkg::RST_RATE;
            start_reg <= kec_pkg::RST_START;
            limit_reg <= kec_pkg::RST_LIMIT;
        end else begin
            // a host write of the enable with rate zero lasts one cycle
            if (req.wr && hit(req, kec_pkg::ADDR_STATUS)) begin
                ctrl_reg <= req.wdata & kec_pkg::CTRL_WMASK;
            end else if (rate_reg == 8'h00) begin
                ctrl_reg[kec_pkg::BIT_REPEAT_EN] <= 1'b0;
            end
            if (req.wr && hit(req, kec_pkg::ADDR_RATE)) begin
                rate_reg <= req.wdata;
            end
            if (req.wr && hit(req, kec_pkg::ADDR_START)) begin
                start_reg <= req.wdata;
            end
            if (req.wr && hit(req, kec_pkg::ADDR_LIMIT)) begin
                limit_reg <= req.wdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // touch limit
    // four keys at most, so three bits never wrap
    function automatic logic [2:0] popcount(input logic [kec_pkg::NUM_KEYS-1:0] v);
        popcount = 3'h0;
        for (int i = 0; i < kec_pkg::NUM_KEYS; i++) begin
            popcount = popcount + {2'h0, v[i]};
        end
    endfunction : popcount

    logic                           over_limit;
    logic [kec_pkg::NUM_KEYS-1:0]   allowed;

    assign over_limit = (limit_reg != 2'h0) && (popcount(touch_s2_reg) > {1'b0, limit_reg});

    // lowest-numbered keys win when the cap bites; predictable over fair
    genvar gk;
    generate
        for (gk = 0; gk < kec_pkg::NUM_KEYS; gk++) begin : g_allow
            if (gk == 0) begin : g_first
                assign allowed[gk] = touch_s2_reg[gk];
            end else begin : g_rest
                assign allowed[gk] = touch_s2_reg[gk] && ((limit_reg == 2'h0) ||
                                     (popcount(touch_s2_reg & ((4'h1 << gk) - 4'h1)) < {1'b0, limit_reg}));
            end
        end
    endgenerate

    assign key_now = allowed;
    assign rise    = key_now & ~key_prev_reg;
    assign fall    = ~key_now & key_prev_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            key_prev_reg <= '0;
            reported_o   <= '0;
            too_many_reg <= 1'b0;
        end else if (meas_tick) begin
            key_prev_reg <= key_now;
            reported_o   <= key_now;
            too_many_reg <= over_limit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // auto-repeat timing, counted in measurements
    function automatic logic [1:0] first_key(input logic [kec_pkg::NUM_KEYS-1:0] v);
        first_key = 2'h0;
        for (int i = kec_pkg::NUM_KEYS - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_key = 2'(i);
            end
        end
    endfunction : first_key

    // only the first newly touched key is tracked; keys touched while it is held never repeat
    assign rep_fire = meas_tick && (rep_state_reg == kec_pkg::KEC_REPEAT) && (rep_cnt_reg == 8'h01)
                      && ctrl_reg[kec_pkg::BIT_REPEAT_EN] && key_now[rep_key_reg];

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rep_state_reg <= kec_pkg::KEC_IDLE;
            rep_cnt_reg   <= 8'h00;
            rep_key_reg   <= 2'h0;
        end else if (meas_tick) begin
            unique case (rep_state_reg)
                kec_pkg::KEC_IDLE: begin
                    if (rise != '0) begin
                        rep_key_reg <= first_key(rise);
                        if (start_reg == 8'h00) begin
                            rep_state_reg <= kec_pkg::KEC_REPEAT;
                            rep_cnt_reg   <= rate_reg;
                        end else begin
                            rep_state_reg <= kec_pkg::KEC_HOLD;
                            rep_cnt_reg   <= start_reg;
                        end
                    end
                end
                kec_pkg::KEC_HOLD: begin
                    if (!key_now[rep_key_reg]) begin
                        rep_state_reg <= kec_pkg::KEC_IDLE;
                    end else if (rep_cnt_reg <= 8'h01) begin
                        rep_state_reg <= kec_pkg::KEC_REPEAT;
                        rep_cnt_reg   <= rate_reg;
                    end else begin
                        rep_cnt_reg <= rep_cnt_reg - 8'h01;
                    end
                end
                kec_pkg::KEC_REPEAT: begin
                    if (!key_now[rep_key_reg]) begin
                        rep_state_reg <= kec_pkg::KEC_IDLE;
                    end else if (rep_cnt_reg <= 8'h01) begin
                        rep_cnt_reg <= rate_reg;
                    end else begin
                        rep_cnt_reg <= rep_cnt_reg - 8'h01;
                    end
                end
                // unused code, fall back to idle
                default: begin
                    rep_state_reg <= kec_pkg::KEC_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event selection into the queue, one per measurement
    kec_pkg::kec_event_t            push_data;
    logic                           push;
    logic                           pop;
    kec_pkg::kec_event_t            head;
    logic                           q_empty;
    logic                           q_full;

    // one event per tick: a release in the same tick as a stored touch is lost
    always_comb begin
        push      = 1'b0;
        push_data = '{kind: kec_pkg::EV_TOUCH, key: 2'h0};
        if (meas_tick && (rise != '0) && ctrl_reg[kec_pkg::BIT_TOUCH_EN]) begin
            push      = 1'b1;
            push_data = '{kind: kec_pkg::EV_TOUCH, key: first_key(rise)};
        end else if (meas_tick && (fall != '0) && ctrl_reg[kec_pkg::BIT_RELEASE_EN]) begin
            push      = 1'b1;
            push_data = '{kind: kec_pkg::EV_RELEASE, key: first_key(fall)};
        end else if (rep_fire) begin
            push      = 1'b1;
            push_data = '{kind: kec_pkg::EV_REPEAT, key: rep_key_reg};
        end
    end

    // popping an empty queue is ignored and reads zero
    assign pop = req.rd && hit(req, kec_pkg::ADDR_QUEUE);

    kec_event_queue u_queue (
        .ref_clk_i   (ref_clk_i),
        .arst_n_i    (arst_n_i),
        .push_i      (push),
        .push_data_i (push_data),
        .pop_i       (pop),
        .head_o      (head),
        .empty_o     (q_empty),
        .full_o      (q_full)
    );

    ////////////////////////////////////////////////////////////////////////////
    // flags and capacitive event
    logic q_full_d_reg;
    logic too_many_d_reg;
    logic cap_set;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q_full_d_reg   <= 1'b0;
            too_many_d_reg <= 1'b0;
            qfull_flag_reg <= 1'b0;
        end else begin
            q_full_d_reg   <= q_full;
            too_many_d_reg <= too_many_reg;
            // edge set: a status read while still full leaves the flag clear
            // set wins over read clear
            if (q_full && !q_full_d_reg) begin
                qfull_flag_reg <= 1'b1;
            end else if (req.rd && hit(req, kec_pkg::ADDR_STATUS)) begin
                qfull_flag_reg <= 1'b0;
            end
        end
    end

    // edge detected, so a flag held high gives a single pulse
    // gated rising flags
    assign cap_set = (ctrl_reg[kec_pkg::BIT_KEYEX_EN] && too_many_reg && !too_many_d_reg) ||
                     (ctrl_reg[kec_pkg::BIT_QFULL_EN] && q_full && !q_full_d_reg);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            cap_event_o  <= 1'b0;
            irq_o        <= 1'b0;
        end else begin
            cap_event_o <= cap_set;
            if (req.wr && hit(req, kec_pkg::ADDR_IRQ_MASK)) begin
                irq_mask_reg <= req.wdata[kec_pkg::IRQ_W-1:0];
            end
            if (cap_set) begin
                irq_stat_reg[kec_pkg::IRQ_CAP_EVENT] <= 1'b1;
            end else if (req.wr && hit(req, kec_pkg::ADDR_IRQ_STAT)) begin
                irq_stat_reg <= irq_stat_reg & ~req.wdata[kec_pkg::IRQ_W-1:0];
            end
            // registered, so the line lags the status bit by one cycle
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, valid the cycle after the strobe
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                kec_pkg::ADDR_STATUS: begin
                    rdata_next = ctrl_reg;
                    rdata_next[kec_pkg::BIT_TOO_MANY] = too_many_reg;
                    rdata_next[kec_pkg::BIT_QFULL]    = qfull_flag_reg;
                end
                kec_pkg::ADDR_RATE:     rdata_next = rate_reg;
                kec_pkg::ADDR_START:    rdata_next = start_reg;
                kec_pkg::ADDR_LIMIT:    rdata_next = {6'h00, limit_reg};
                // empty queue reads zero; kind zero is never a real event
                kec_pkg::ADDR_QUEUE:    rdata_next = q_empty ? 8'h00 : {4'h0, head};
                kec_pkg::ADDR_IRQ_STAT: rdata_next = {7'h00, irq_stat_reg};
                kec_pkg::ADDR_IRQ_MASK: rdata_next = {7'h00, irq_mask_reg};
                default:                rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rdata_next;
        end
    end
endmodule : kec_keypad_events

// *** rtl/kec_pkg.sv ***
// package: register map, field layout and types for the keypad event control
package kec_pkg;
    localparam int unsigned NUM_KEYS        = 4;
    localparam int unsigned QUEUE_DEPTH     = 16;
    localparam int unsigned QUEUE_AW        = 4;

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_STATUS     = 8'h00;
    localparam logic [7:0] ADDR_RATE       = 8'h04;
    localparam logic [7:0] ADDR_START      = 8'h08;
    localparam logic [7:0] ADDR_LIMIT      = 8'h0C;
    localparam logic [7:0] ADDR_QUEUE      = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;

    // status/control bit positions
    localparam int unsigned BIT_TOO_MANY    = 7;
    localparam int unsigned BIT_QFULL       = 6;
    localparam int unsigned BIT_KEYEX_EN    = 4;
    localparam int unsigned BIT_QFULL_EN    = 3;
    localparam int unsigned BIT_REPEAT_EN   = 2;
    localparam int unsigned BIT_RELEASE_EN  = 1;
    localparam int unsigned BIT_TOUCH_EN    = 0;
    localparam logic [7:0] CTRL_WMASK      = 8'h1F;

    // interrupt status bit positions
    localparam int unsigned IRQ_CAP_EVENT   = 0;
    localparam int unsigned IRQ_W           = 1;

    // reset values
    localparam logic [7:0] RST_CTRL        = 8'h03;
    localparam logic [7:0] RST_RATE        = 8'h00;
    localparam logic [7:0] RST_START       = 8'h00;
    localparam logic [1:0] RST_LIMIT       = 2'h0;

    // queue entry kinds
    localparam logic [1:0] EV_TOUCH        = 2'h1;
    localparam logic [1:0] EV_RELEASE      = 2'h2;
    localparam logic [1:0] EV_REPEAT       = 2'h3;

    typedef struct packed {
        logic [1:0] kind;
        logic [1:0] key;
    } kec_event_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } kec_bus_req_t;

    typedef enum logic [1:0] {
        KEC_IDLE   = 2'b00,
        KEC_HOLD   = 2'b01,
        KEC_REPEAT = 2'b10
    } kec_rep_state_t;
endpackage : kec_pkg

// *** rtl/kec_event_queue.sv ***
// 16-entry event queue that refuses writes when full
`timescale 1ns/1ps
module kec_event_queue (
    input  wire logic               ref_clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               push_i,
    input  kec_pkg::kec_event_t     push_data_i,
    input  wire logic               pop_i,
    output kec_pkg::kec_event_t     head_o,
    output logic                    empty_o,
    output logic                    full_o
);
    kec_pkg::kec_event_t                store [kec_pkg::QUEUE_DEPTH];
    logic [kec_pkg::QUEUE_AW-1:0]       wr_ptr_reg;
    logic [kec_pkg::QUEUE_AW-1:0]       rd_ptr_reg;
    logic [kec_pkg::QUEUE_AW:0]         count_reg;
    logic                               do_push;
    logic                               do_pop;

    assign full_o  = (count_reg == 5'(kec_pkg::QUEUE_DEPTH));
    assign empty_o = (count_reg == 5'h00);
    assign do_push = push_i && !full_o;
    assign do_pop  = pop_i && !empty_o;
    assign head_o  = store[rd_ptr_reg];

    always_ff @(posedge ref_clk_i) begin
        if (do_push) begin
            store[wr_ptr_reg] <= push_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_reg  <= 5'h00;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 4'h1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 4'h1;
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 5'h01;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 5'h01;
            end
        end
    end
endmodule : kec_event_queue

// *** verif/kec_front_model.sv ***
// sensing front-end model: holds key levels and makes one measurement pulse per request
`timescale 1ns/1ps
module kec_front_model (
    input  wire logic                         ref_clk_i,
    input  wire logic                         arst_n_i,
    input  wire logic                         tick_req_i,
    input  wire logic [kec_pkg::NUM_KEYS-1:0] keys_i,
    output logic      [kec_pkg::NUM_KEYS-1:0] touch_o,
    output logic                              meas_o
);
    logic [3:0] cnt_reg;
    ////////////////////////////////////////////////////////////////
    // keys settle three cycles before the pulse so the sync sees them first
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 4'h0;
            touch_o <= '0;
        end else if (tick_req_i) begin
            cnt_reg <= 4'h1;
            touch_o <= keys_i;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // high four cycles, then low: wider than the two-cycle minimum
    assign meas_o = (cnt_reg >= 4'h4) && (cnt_reg < 4'h8);
endmodule : kec_front_model

// *** verif/kec_keypad_events_checker.sv ***
// port-level assertions for the keypad event block
`timescale 1ns/1ps
module kec_keypad_events_checker (
    input wire logic                         ref_clk_i,
    input wire logic                         arst_n_i,
    input wire logic [7:0]                   addr_i,
    input wire logic [7:0]                   wdata_i,
    input wire logic                         wr_i,
    input wire logic                         rd_i,
    input wire logic [7:0]                   rdata_o,
    input wire logic [kec_pkg::NUM_KEYS-1:0] reported_o,
    input wire logic                         cap_event_o,
    input wire logic                         irq_o
);
    logic [4:0] ctrl_sh;
    logic [4:0] ctrl_q;
    logic [7:0] rate_sh;
    logic [1:0] lim_sh;
    logic       mask_sh;
    logic [1:0] rz_cnt;
    logic       rzr_q;
    logic       rds_q;
    logic       rdq_q;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////
    // shadows of host writes; repeat enable is shadowed but left out of the readback compare as the device clears it
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_sh <= kec_pkg::RST_CTRL[4:0];
            rate_sh <= kec_pkg::RST_RATE;
            lim_sh  <= kec_pkg::RST_LIMIT;
            mask_sh <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == kec_pkg::ADDR_STATUS) ctrl_sh <= wdata_i[4:0];
            if (addr_i == kec_pkg::ADDR_RATE) rate_sh <= wdata_i;
            if (addr_i == kec_pkg::ADDR_LIMIT) lim_sh <= wdata_i[1:0];
            if (addr_i == kec_pkg::ADDR_IRQ_MASK) mask_sh <= wdata_i[0];
        end
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rz_cnt <= 2'h0;
            rzr_q  <= 1'b0;
            rds_q  <= 1'b0;
            rdq_q  <= 1'b0;
            ctrl_q <= kec_pkg::RST_CTRL[4:0];
        end else begin
            if ((wr_i && addr_i == kec_pkg::ADDR_STATUS) || rate_sh != 8'h00) rz_cnt <= 2'h0;
            else if (rz_cnt != 2'h3) rz_cnt <= rz_cnt + 2'h1;
            rzr_q  <= (rz_cnt >= 2'h2);
            rds_q  <= rd_i && (addr_i == kec_pkg::ADDR_STATUS);
            rdq_q  <= rd_i && (addr_i == kec_pkg::ADDR_QUEUE);
            ctrl_q <= ctrl_sh;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_cap_pulse_single: assert property (cap_event_o |=> !cap_event_o)
        else $error("capacitive event longer than one cycle");
    a_touch_limit_cap: assert property ($changed(reported_o) && lim_sh != 2'h0 |->
        $countones(reported_o) <= lim_sh)
        else $error("more keys reported than the limit");
    a_ctrl_readback: assert property (rds_q |->
        {rdata_o[5:3], rdata_o[1:0]} == {1'b0, ctrl_q[4:3], ctrl_q[1:0]})
        else $error("control bits read back wrong");
    a_rate_zero_clear: assert property (rds_q && rzr_q |-> !rdata_o[2])
        else $error("repeat enable kept with rate zero");
    a_irq_raise: assert property (cap_event_o && mask_sh |-> ##[1:3] irq_o)
        else $error("unmasked event gave no interrupt");
    a_irq_masked: assert property (!mask_sh && !$past(mask_sh) |-> !irq_o)
        else $error("interrupt while masked");
    a_queue_format: assert property (rdq_q |-> rdata_o[7:4] == 4'h0)
        else $error("queue entry upper bits not zero");
endmodule : kec_keypad_events_checker

bind kec_keypad_events kec_keypad_events_checker u_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .reported_o(reported_o), .cap_event_o(cap_event_o), .irq_o(irq_o));

// *** verif/tb_kec_keypad_events.sv ***
// register-level testbench for the keypad event block
`timescale 1ns/1ps
module tb_kec_keypad_events;
    logic       ref_clk_i = 1'b0;
    logic       arst_n_i  = 1'b0;
    logic [7:0] addr      = 8'h00;
    logic [7:0] wdata     = 8'h00;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic       req       = 1'b0;
    logic [3:0] keys      = 4'h0;
    logic [3:0] touch;
    logic       meas;
    logic [7:0] rdata;
    logic [3:0] reported;
    logic       cap_ev;
    logic       irq;
    int         num_errors = 0;
    int         checks     = 0;
    int         cap_count  = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    // summary event pulses stand one cycle, so each is counted once
    always @(posedge ref_clk_i) begin
        if (cap_ev) cap_count++;
    end
    kec_front_model u_fe (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .tick_req_i(req), .keys_i(keys),
        .touch_o(touch), .meas_o(meas));
    kec_keypad_events dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .touch_i(touch), .meas_done_i(meas),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .reported_o(reported),
        .cap_event_o(cap_ev), .irq_o(irq));
    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_i);
        wr    <= 1'b0;
    endtask : wr_reg
    // read data only stand in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk_i);
        rd   <= 1'b0;
        @(negedge ref_clk_i);
        chk($sformatf("rdata at %h", a), rdata, exp);
    endtask : rdc
    // one measurement with the given key levels, long enough for the sync chain
    task automatic tick(input logic [3:0] k);
        @(posedge ref_clk_i);
        keys <= k;
        req  <= 1'b1;
        @(posedge ref_clk_i);
        req  <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
    endtask : tick
    ////////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        rdc(kec_pkg::ADDR_STATUS, kec_pkg::RST_CTRL);
        rdc(kec_pkg::ADDR_RATE, kec_pkg::RST_RATE);
        rdc(kec_pkg::ADDR_START, kec_pkg::RST_START);
        rdc(kec_pkg::ADDR_LIMIT, 8'h00);
        rdc(kec_pkg::ADDR_IRQ_MASK, 8'h00);
        rdc(8'h1C, 8'h00);
        // touch then release, both stored by default
        tick(4'h1);
        tick(4'h0);
        rdc(kec_pkg::ADDR_QUEUE, {4'h0, kec_pkg::EV_TOUCH, 2'h0});
        rdc(kec_pkg::ADDR_QUEUE, {4'h0, kec_pkg::EV_RELEASE, 2'h0});
        rdc(kec_pkg::ADDR_QUEUE, 8'h00);
        wr_reg(kec_pkg::ADDR_STATUS, 8'h00);
        tick(4'h1);
        tick(4'h0);
        rdc(kec_pkg::ADDR_QUEUE, 8'h00);
        // repeat: start 1, rate 2, key 1 held six more measurements
        wr_reg(kec_pkg::ADDR_RATE, 8'h02);
        wr_reg(kec_pkg::ADDR_START, 8'h01);
        wr_reg(kec_pkg::ADDR_STATUS, 8'h05);
        repeat (7) tick(4'h2);
        tick(4'h0);
        rdc(kec_pkg::ADDR_QUEUE, {4'h0, kec_pkg::EV_TOUCH, 2'h1});
        rdc(kec_pkg::ADDR_QUEUE, {4'h0, kec_pkg::EV_REPEAT, 2'h1});
        rdc(kec_pkg::ADDR_QUEUE, {4'h0, kec_pkg::EV_REPEAT, 2'h1});
        rdc(kec_pkg::ADDR_QUEUE, 8'h00);
        // zero rate drops the repeat enable by itself
        wr_reg(kec_pkg::ADDR_RATE, 8'h00);
        rdc(kec_pkg::ADDR_STATUS, 8'h01);
        // eighteen events into sixteen places
        wr_reg(kec_pkg::ADDR_STATUS, 8'h0B);
        wr_reg(kec_pkg::ADDR_IRQ_MASK, 8'h01);
        repeat (9) begin
            tick(4'h1);
            tick(4'h0);
        end
        chk("irq", {7'h00, irq}, 8'h01);
        chk("cap events", 8'(cap_count), 8'h01);
        rdc(kec_pkg::ADDR_STATUS, 8'h4B);
        rdc(kec_pkg::ADDR_STATUS, 8'h0B);
        for (int i = 0; i < 16; i++) begin
            rdc(kec_pkg::ADDR_QUEUE, {4'h0, (i % 2 == 0) ? kec_pkg::EV_TOUCH : kec_pkg::EV_RELEASE, 2'h0});
        end
        rdc(kec_pkg::ADDR_QUEUE, 8'h00);
        wr_reg(kec_pkg::ADDR_IRQ_STAT, 8'h01);
        repeat (3) @(posedge ref_clk_i);
        chk("irq", {7'h00, irq}, 8'h00);
        // start zero, rate one: repeats from the first held measurement on
        wr_reg(kec_pkg::ADDR_RATE, 8'h01);
        wr_reg(kec_pkg::ADDR_START, 8'h00);
        wr_reg(kec_pkg::ADDR_STATUS, 8'h05);
        repeat (3) tick(4'h4);
        tick(4'h0);
        rdc(kec_pkg::ADDR_QUEUE, {4'h0, kec_pkg::EV_TOUCH, 2'h2});
        rdc(kec_pkg::ADDR_QUEUE, {4'h0, kec_pkg::EV_REPEAT, 2'h2});
        rdc(kec_pkg::ADDR_QUEUE, {4'h0, kec_pkg::EV_REPEAT, 2'h2});
        rdc(kec_pkg::ADDR_QUEUE, 8'h00);
        // two keys against a limit of one
        wr_reg(kec_pkg::ADDR_STATUS, 8'h13);
        wr_reg(kec_pkg::ADDR_LIMIT, 8'h01);
        tick(4'h3);
        chk("reported", {4'h0, reported}, 8'h01);
        chk("irq", {7'h00, irq}, 8'h01);
        chk("cap events", 8'(cap_count), 8'h02);
        rdc(kec_pkg::ADDR_STATUS, 8'h93);
        tick(4'h1);
        rdc(kec_pkg::ADDR_STATUS, 8'h13);
        // keys-exceeded event off: flag still rises, no summary event
        wr_reg(kec_pkg::ADDR_STATUS, 8'h03);
        tick(4'h3);
        rdc(kec_pkg::ADDR_STATUS, 8'h83);
        chk("cap events", 8'(cap_count), 8'h02);
        complete_run();
    end
endmodule : tb_kec_keypad_events
